// ==== bbs_host_model.sv ====
`timescale 1ns/10ps
module bbs_host_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the bench.
   input wire logic fail_req,
   input wire logic ask_str,
   input wire logic [4:0] pin_sel,
   // Function state as the host sees it.
   input wire logic func_connect,
   input wire logic bb_mode,
   // Stimulus to the sequencer.
   output logic [16:0] general_purpose_pin,
   output logic addr_set,
   output logic alt_str_req
);
   logic [3:0] cnt_q;
   // The controller pulls only the selected pin low; the rest idle high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) general_purpose_pin <= '1;
      else if (fail_req)
         general_purpose_pin <= ~(17'h1 << pin_sel);
      else general_purpose_pin <= '1;
   end
   // The host addresses the function once, soon after a Billboard attach,
   // then asks for the string once; no retries, so spans stay predictable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         addr_set <= 1'b0;
         alt_str_req <= 1'b0;
      end else begin
         if (func_connect && bb_mode) cnt_q <= cnt_q + 4'(cnt_q != 4'hF);
         else cnt_q <= 4'h0;
         addr_set <= func_connect && bb_mode && cnt_q == 4'h3;
         alt_str_req <= ask_str && func_connect && bb_mode && cnt_q == 4'h5;
      end
   end
endmodule : bbs_host_model

// ==== bbs_pkg.sv ====
package bbs_pkg;
   // APB byte address width; each register index sits at four times itself.
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_TMR_A_LO = 16'h413C;
   localparam logic [15:0] IDX_TMR_A_HI = 16'h413D;
   localparam logic [15:0] IDX_TMR_B_LO = 16'h413E;
   localparam logic [15:0] IDX_TMR_B_HI = 16'h413F;
   localparam logic [15:0] IDX_CTRL = 16'h4140;
   localparam logic [15:0] IDX_DESC = 16'h4141;
   localparam logic [15:0] IDX_STAT = 16'h4142;
   // Reset values.
   localparam logic [7:0] RST_TMR_A_LO = 8'hD0;
   localparam logic [7:0] RST_TMR_A_HI = 8'h07;
   localparam logic [7:0] RST_TMR_B_LO = 8'hD0;
   localparam logic [7:0] RST_TMR_B_HI = 8'h07;
   localparam logic [7:0] RST_CTRL = 8'h14;
   localparam logic [1:0] RST_BM_CFG = 2'h0;
   localparam logic [7:0] RST_ALT_IDX = 8'h02;
   localparam logic [7:0] RST_URL_IDX = 8'h01;
   // Field positions.
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SEL_LSB = 1;
   localparam int CTRL_SEL_W = 5;
   localparam logic [7:0] CTRL_MASK = 8'h3F;
   localparam int DESC_BM_LSB = 0;
   localparam int DESC_ALT_LSB = 8;
   localparam int DESC_URL_LSB = 16;
   // Request pin selection.
   localparam int NUM_PINS = 17;
   localparam logic [4:0] SEL_RESERVED = 5'h09;
   // Timing: one timer count is 10 ms.
   localparam int TICK_MS = 10;
   localparam int CLK_MHZ = 125;
   localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
   localparam int DETACH_MS = 10;
   localparam logic [7:0] DETACH_TICKS =
      8'((DETACH_MS + TICK_MS - 1) / TICK_MS);
   typedef enum logic [1:0] {
      ST_STD, ST_DET_BB, ST_BB, ST_DET_STD
   } bbs_state_t;
   typedef struct packed {
      logic [7:0] url_idx;
      logic [7:0] alt_idx;
      logic [1:0] bm_cfg;
   } bbs_desc_t;
endpackage : bbs_pkg

// ==== bbs_sequencer.sv ====
// What this block does
// - Selected request low forces function detach.
// - Reconnect afterwards with Billboard class descriptors.
// - Address set while Billboard starts timer one.
// - Timer one defaults to twenty seconds.
// - Billboard only on failure; configured field 00b.
// - Alternate string request answered, starts timer two.
// - Timer two defaults to twenty seconds.
// - Either timer expiring forces function detach.
// - Then reconnect with standard descriptors.
// - Sixteen-bit timeouts in byte pairs, 10 ms counts.
// - Timer one byte pair resets to 2000.
// - String and URL descriptor indices are configurable.
// - Request input is active low from controller.
// - Support enable bit zero gates the start of an episode only.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module bbs_sequencer #(
   parameter int unsigned TICK_CYCLES = bbs_pkg::TICK_CYC
) (
   // Clock, reset, enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [bbs_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins from the power-delivery controller.
   input wire logic [bbs_pkg::NUM_PINS-1:0] general_purpose_pin,
   // Events from the function core, same clock.
   input wire logic addr_set,
   input wire logic alt_str_req,
   // Control of the function core.
   output logic func_connect,
   output logic bb_mode,
   output logic alt_str_grant,
   output bbs_pkg::bbs_desc_t desc
);
   logic [7:0] tmr_a_lo_q, tmr_a_hi_q, tmr_b_lo_q, tmr_b_hi_q;
   logic [7:0] ctrl_q;
   bbs_pkg::bbs_desc_t desc_q;
   logic [31:0] prdata_q, rd_data;
   logic pready_q, pslverr_q, hit, wr_en;
   logic [bbs_pkg::NUM_PINS-1:0] pin_s1_q, pin_s2_q;
   logic [4:0] sel;
   logic en, req_low, served_q;
   bbs_pkg::bbs_state_t state_q, state_d;
   logic [20:0] pre_q;
   logic tick;
   logic [7:0] det_q;
   logic det_done;
   logic a_run_q, b_run_q;
   logic [15:0] a_cnt_q, b_cnt_q;
   logic exp_a, exp_b;
   logic connect_q, bb_q, grant_q;

   // Register decode; printed indices are scaled to word addresses.
   always_comb begin
      hit = 1'b1;
      rd_data = 32'h0;
      case (paddr)
         {bbs_pkg::IDX_TMR_A_LO, 2'b00}: rd_data[7:0] = tmr_a_lo_q;
         {bbs_pkg::IDX_TMR_A_HI, 2'b00}: rd_data[7:0] = tmr_a_hi_q;
         {bbs_pkg::IDX_TMR_B_LO, 2'b00}: rd_data[7:0] = tmr_b_lo_q;
         {bbs_pkg::IDX_TMR_B_HI, 2'b00}: rd_data[7:0] = tmr_b_hi_q;
         {bbs_pkg::IDX_CTRL, 2'b00}: rd_data[7:0] = ctrl_q;
         {bbs_pkg::IDX_DESC, 2'b00}: begin
            rd_data[bbs_pkg::DESC_BM_LSB +: 2] = desc_q.bm_cfg;
            rd_data[bbs_pkg::DESC_ALT_LSB +: 8] = desc_q.alt_idx;
            rd_data[bbs_pkg::DESC_URL_LSB +: 8] = desc_q.url_idx;
         end
         {bbs_pkg::IDX_STAT, 2'b00}:
            rd_data[5:0] = {served_q, b_run_q, a_run_q, req_low, state_q};
         default: hit = 1'b0;
      endcase
   end

   assign wr_en = ce && psel && penable && pwrite && pready_q;

   // Answer is ready in the first access cycle, so no wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q <= psel && !penable;
         prdata_q <= (psel && !penable && !pwrite) ? rd_data : 32'h0;
         pslverr_q <= psel && !penable && !hit;
      end
   end

   // Timeout byte pairs; writes only land on the completing edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_a_lo_q <= bbs_pkg::RST_TMR_A_LO;
         tmr_a_hi_q <= bbs_pkg::RST_TMR_A_HI;
         tmr_b_lo_q <= bbs_pkg::RST_TMR_B_LO;
         tmr_b_hi_q <= bbs_pkg::RST_TMR_B_HI;
      end else if (wr_en) begin
         if (paddr == {bbs_pkg::IDX_TMR_A_LO, 2'b00})
            tmr_a_lo_q <= pwdata[7:0];
         if (paddr == {bbs_pkg::IDX_TMR_A_HI, 2'b00})
            tmr_a_hi_q <= pwdata[7:0];
         if (paddr == {bbs_pkg::IDX_TMR_B_LO, 2'b00})
            tmr_b_lo_q <= pwdata[7:0];
         if (paddr == {bbs_pkg::IDX_TMR_B_HI, 2'b00})
            tmr_b_hi_q <= pwdata[7:0];
      end
   end

   // Control and descriptor configuration.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= bbs_pkg::RST_CTRL;
         desc_q.bm_cfg <= bbs_pkg::RST_BM_CFG;
         desc_q.alt_idx <= bbs_pkg::RST_ALT_IDX;
         desc_q.url_idx <= bbs_pkg::RST_URL_IDX;
      end else if (wr_en) begin
         if (paddr == {bbs_pkg::IDX_CTRL, 2'b00})
            ctrl_q <= pwdata[7:0] & bbs_pkg::CTRL_MASK;
         if (paddr == {bbs_pkg::IDX_DESC, 2'b00}) begin
            desc_q.bm_cfg <= pwdata[bbs_pkg::DESC_BM_LSB +: 2];
            desc_q.alt_idx <= pwdata[bbs_pkg::DESC_ALT_LSB +: 8];
            desc_q.url_idx <= pwdata[bbs_pkg::DESC_URL_LSB +: 8];
         end
      end
   end

   // Pins come from another chip, so two flops before any use.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= '1;
         pin_s2_q <= '1;
      end else if (ce) begin
         pin_s1_q <= general_purpose_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // A reserved or out-of-range selection never requests.
   assign en = ctrl_q[bbs_pkg::CTRL_EN_BIT];
   assign sel = ctrl_q[bbs_pkg::CTRL_SEL_LSB +: bbs_pkg::CTRL_SEL_W];
   assign req_low = (sel != bbs_pkg::SEL_RESERVED)
      && (32'(sel) < bbs_pkg::NUM_PINS)
      && !pin_s2_q[sel];

   // Free-running 10 ms prescaler; a timer may lose up to one tick.
   assign tick = (pre_q == 21'(TICK_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pre_q <= 21'h0;
      else if (ce)
         pre_q <= tick ? 21'h0 : pre_q + 21'h1;
   end

   // Detach hold: the function stays off the port until the next tick, up to one tick.
   assign det_done = tick && (det_q == bbs_pkg::DETACH_TICKS - 8'h01);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         det_q <= 8'h0;
      else if (ce) begin
         if (state_q != state_d)
            det_q <= 8'h0;
         else if (tick)
            det_q <= det_q + 8'h01;
      end
   end

   // Expiry once the count reaches the programmed limit.
   assign exp_a = a_run_q && tick
      && ({1'b0, a_cnt_q} + 17'h1 >= {1'b0, tmr_a_hi_q, tmr_a_lo_q});
   assign exp_b = b_run_q && tick
      && ({1'b0, b_cnt_q} + 17'h1 >= {1'b0, tmr_b_hi_q, tmr_b_lo_q});

   // Sequencer.
   always_comb begin
      state_d = state_q;
      case (state_q)
         bbs_pkg::ST_STD:
            if (en && req_low && !served_q)
               state_d = bbs_pkg::ST_DET_BB;
         bbs_pkg::ST_DET_BB:
            if (det_done)
               state_d = bbs_pkg::ST_BB;
         bbs_pkg::ST_BB:
            if (exp_a || exp_b)
               state_d = bbs_pkg::ST_DET_STD;
         bbs_pkg::ST_DET_STD:
            if (det_done)
               state_d = bbs_pkg::ST_STD;
         default: state_d = bbs_pkg::ST_STD;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state_q <= bbs_pkg::ST_STD;
      else if (ce)
         state_q <= state_d;
   end

   // A held request must go high again before a second episode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         served_q <= 1'b0;
      else if (ce) begin
         if (state_q == bbs_pkg::ST_DET_STD && det_done)
            served_q <= 1'b1;
         else if (!req_low)
            served_q <= 1'b0;
      end
   end

   // Timer one runs from the address assignment.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_run_q <= 1'b0;
         a_cnt_q <= 16'h0;
      end else if (ce) begin
         if (state_q != bbs_pkg::ST_BB) begin
            a_run_q <= 1'b0;
            a_cnt_q <= 16'h0;
         end else if (addr_set && !a_run_q) begin
            a_run_q <= 1'b1;
            a_cnt_q <= 16'h0;
         end else if (a_run_q && tick)
            a_cnt_q <= a_cnt_q + 16'h1;
      end
   end

   // Timer two runs from the alternate string request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_run_q <= 1'b0;
         b_cnt_q <= 16'h0;
      end else if (ce) begin
         if (state_q != bbs_pkg::ST_BB) begin
            b_run_q <= 1'b0;
            b_cnt_q <= 16'h0;
         end else if (alt_str_req && !b_run_q) begin
            b_run_q <= 1'b1;
            b_cnt_q <= 16'h0;
         end else if (b_run_q && tick)
            b_cnt_q <= b_cnt_q + 16'h1;
      end
   end

   // Outputs to the function core, all registered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         connect_q <= 1'b1;
         bb_q <= 1'b0;
         grant_q <= 1'b0;
      end else if (ce) begin
         connect_q <= state_d == bbs_pkg::ST_STD
            || state_d == bbs_pkg::ST_BB;
         bb_q <= state_d == bbs_pkg::ST_BB;
         grant_q <= alt_str_req && state_q == bbs_pkg::ST_BB;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign func_connect = connect_q;
   assign bb_mode = bb_q;
   assign alt_str_grant = grant_q;
   assign desc = desc_q;

   // Checks.
   a_req_detach: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_STD && en && req_low && !served_q
      |=> !func_connect)
      else $error("Request did not force detach.");
   a_bb_reconnect: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_DET_BB && det_done
      |=> func_connect && bb_mode)
      else $error("No Billboard reconnect.");
   a_timer_one_start: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_BB && addr_set && !a_run_q
      |=> a_run_q && a_cnt_q == 16'h0)
      else $error("Timer one did not start.");
   a_alt_grant: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_BB && alt_str_req && !b_run_q
      |=> alt_str_grant && b_run_q)
      else $error("String request not served.");
   a_expire_detach: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_BB && (exp_a || exp_b)
      |=> !func_connect && !bb_mode)
      else $error("Expiry did not detach.");
   a_std_reconnect: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_DET_STD && det_done
      |=> func_connect && !bb_mode)
      else $error("No standard reconnect.");
   a_disable_ignore: assert property (@(posedge pclk)
      disable iff (!presetn)
      state_q == bbs_pkg::ST_STD && !en |=> state_q == bbs_pkg::ST_STD)
      else $error("Disabled block left standard state.");
   a_timers_clear: assert property (@(posedge pclk)
      disable iff (!presetn)
      ce && state_q == bbs_pkg::ST_DET_STD
      |=> !a_run_q && !b_run_q && a_cnt_q == 16'h0 && b_cnt_q == 16'h0)
      else $error("Timers not cleared on detach.");
endmodule : bbs_sequencer

// ==== tb_billboard_attach_sequencer.sv ====
`timescale 1ns/10ps
module tb_billboard_attach_sequencer;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [16:0] general_purpose_pin;
   logic addr_set, alt_str_req, func_connect, bb_mode, alt_str_grant;
   logic fail_req, ask_str;
   logic [4:0] pin_sel;
   bbs_pkg::bbs_desc_t desc;
   int failures, samples_checked, n, grants, g0;
   // A short tick keeps the tested timeouts of two and three ticks within a few dozen cycles.
   bbs_sequencer #(.TICK_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn),
      .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .general_purpose_pin(general_purpose_pin),
      .addr_set(addr_set), .alt_str_req(alt_str_req),
      .func_connect(func_connect), .bb_mode(bb_mode),
      .alt_str_grant(alt_str_grant), .desc(desc));
   bbs_host_model host_u (.pclk(pclk), .presetn(presetn),
      .fail_req(fail_req), .ask_str(ask_str), .pin_sel(pin_sel),
      .func_connect(func_connect), .bb_mode(bb_mode),
      .general_purpose_pin(general_purpose_pin), .addr_set(addr_set),
      .alt_str_req(alt_str_req));
   // Free-running clock, 8 ns period.
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Grant pulses are counted apart from the scenario that causes them.
   always @(posedge pclk) begin
      if (alt_str_grant === 1'b1) grants++;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [15:0] idx,
      input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input string nm, input logic [15:0] idx,
      input logic [31:0] e);
      apb(1'b0, idx, 32'h0);
      chk(nm, rd, e);
   endtask : rdc
   // Counts edges until the attach level matches, bounded.
   task automatic wait_fc(input logic v);
      n = 0;
      while (func_connect !== v && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 9000) failures++;
   endtask : wait_fc
   task automatic t_regs;
      chk("desc", 32'(desc), {14'h0, 8'h01, 8'h02, 2'h0});
      rdc("a_lo", bbs_pkg::IDX_TMR_A_LO, 32'hD0);
      rdc("a_hi", bbs_pkg::IDX_TMR_A_HI, 32'h07);
      rdc("b_lo", bbs_pkg::IDX_TMR_B_LO, 32'hD0);
      rdc("b_hi", bbs_pkg::IDX_TMR_B_HI, 32'h07);
      rdc("ctrl", bbs_pkg::IDX_CTRL, 32'h14);
      rdc("descr", bbs_pkg::IDX_DESC, 32'h00010200);
      apb(1'b1, bbs_pkg::IDX_TMR_A_LO, 32'hFFFFFF5A);
      rdc("a_lo_wr", bbs_pkg::IDX_TMR_A_LO, 32'h5A);
      apb(1'b1, bbs_pkg::IDX_CTRL, 32'hFF);
      rdc("ctrl_wr", bbs_pkg::IDX_CTRL, 32'h3F);
      apb(1'b1, bbs_pkg::IDX_DESC, 32'h00050603);
      // The write lands on the edge the task returns at; let it settle.
      @(posedge pclk);
      chk("desc_wr", 32'(desc), {14'h0, 8'h05, 8'h06, 2'h3});
      rdc("unmapped", 16'h4143, 32'h0);
      chk("unmapped_err", 32'(err), 32'h1);
   endtask : t_regs
   task automatic t_gate;
      apb(1'b1, bbs_pkg::IDX_CTRL, 32'h14);
      pin_sel <= 5'd10;
      fail_req <= 1'b1;
      repeat (40) @(posedge pclk);
      chk("fc_off", 32'(func_connect), 32'h1);
      apb(1'b1, bbs_pkg::IDX_CTRL, 32'h13);
      pin_sel <= 5'd9;
      repeat (40) @(posedge pclk);
      chk("fc_resv", 32'(func_connect), 32'h1);
      fail_req <= 1'b0;
   endtask : t_gate
   task automatic t_timer_a;
      apb(1'b1, bbs_pkg::IDX_TMR_A_LO, 32'h03);
      apb(1'b1, bbs_pkg::IDX_TMR_A_HI, 32'h00);
      apb(1'b1, bbs_pkg::IDX_CTRL, 32'h07);
      pin_sel <= 5'd3;
      fail_req <= 1'b1;
      wait_fc(1'b0);
      chk("detach", 32'(n < 60), 32'h1);
      wait_fc(1'b1);
      chk("bb_on", 32'(bb_mode), 32'h1);
      wait_fc(1'b0);
      chk("a_span", 32'(n >= 21 && n <= 31), 32'h1);
      wait_fc(1'b1);
      chk("std_a", 32'(bb_mode), 32'h0);
      fail_req <= 1'b0;
   endtask : t_timer_a
   task automatic t_timer_b;
      repeat (8) @(posedge pclk);
      apb(1'b1, bbs_pkg::IDX_TMR_A_LO, 32'hD0);
      apb(1'b1, bbs_pkg::IDX_TMR_A_HI, 32'h07);
      apb(1'b1, bbs_pkg::IDX_TMR_B_LO, 32'h02);
      apb(1'b1, bbs_pkg::IDX_TMR_B_HI, 32'h00);
      ask_str <= 1'b1;
      g0 = grants;
      fail_req <= 1'b1;
      wait_fc(1'b0);
      wait_fc(1'b1);
      wait_fc(1'b0);
      chk("b_span", 32'(n >= 15 && n <= 22), 32'h1);
      chk("grants", 32'(grants - g0), 32'h1);
      fail_req <= 1'b0;
      ask_str <= 1'b0;
      wait_fc(1'b1);
      chk("std_b", 32'(bb_mode), 32'h0);
      repeat (4) @(posedge pclk);
      apb(1'b0, bbs_pkg::IDX_STAT, 32'h0);
      chk("stat", rd & 32'h1B, 32'h0);
   endtask : t_timer_b
   task automatic results;
      if (failures == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // Main sequence; reset is held for four edges.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      fail_req = 1'b0;
      ask_str = 1'b0;
      pin_sel = 5'd3;
      failures = 0;
      samples_checked = 0;
      grants = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_gate;
      t_timer_a;
      t_timer_b;
      results;
   end
   // The whole run needs well under a thousand cycles.
   initial begin
      repeat (60000) @(posedge pclk);
      failures++;
      results;
   end
endmodule : tb_billboard_attach_sequencer
